/* File: design/ifp_pkg.sv */
// Package of constants and carrier types for the interrupt flag and power control block.
// Function
// - Enable bit per extra pin, bit7=pin9.
// - Enabled pin wakes regardless of global enable.
// - Pin request needs low-volt gate too.
// - Pin flags set by hardware, zero clears.
// - PWM flags set by hardware, zero clears.
// - Power bit7 doubles first UART baud.
// - Power bit1 one enters stop mode.
// - Power bit0 one enters idle mode.
// - Power bits3,2 plain spare flags.
// - Timer1 overflow sets bit7, vector clears.
// - Timer0 overflow sets bit5, vector clears.
// - Bits6,4 run timer1 and timer0.
// - Pin1 falling edge sets bit3 in edge mode, vector clears.
// - Pin0 falling edge sets bit1 in edge mode, vector clears.
// - Bit2 selects pin1 level or edge.
// - Bit0 selects pin0 level or edge.
package ifp_pkg;
	localparam logic [7:0] OFS_PIN_EN = 8'h84;
	localparam logic [7:0] OFS_PIN_FLAGS = 8'h85;
	localparam logic [7:0] OFS_PWM_FLAGS = 8'h86;
	localparam logic [7:0] OFS_POWER = 8'h87;
	localparam logic [7:0] OFS_TCTRL = 8'h88;
	localparam logic [7:0] OFS_CTRL = 8'h8c;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h90;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h94;
	localparam int BIT_DOUBLE_BAUD = 7;
	localparam int BIT_SPARE1 = 3;
	localparam int BIT_SPARE0 = 2;
	localparam int BIT_POWER_DOWN = 1;
	localparam int BIT_IDLE = 0;
	localparam int BIT_T1_OVF = 7;
	localparam int BIT_T1_RUN = 6;
	localparam int BIT_T0_OVF = 5;
	localparam int BIT_T0_RUN = 4;
	localparam int BIT_P1_EDGE = 3;
	localparam int BIT_P1_TRIG = 2;
	localparam int BIT_P0_EDGE = 1;
	localparam int BIT_P0_TRIG = 0;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] POWER_RW_MASK = 8'h8f;
	localparam logic [7:0] PWM_FLAG_MASK = 8'h07;
	localparam logic [31:0] READ_UNMAPPED = 32'h00000000;
	// Vector acknowledge codes from the core.
	typedef enum logic [2:0] {
		ACK_NONE, ACK_PIN0, ACK_TIMER0, ACK_PIN1, ACK_TIMER1
	} ifp_ack_t;
	// Pin-side and event inputs grouped together.
	typedef struct packed {
		logic [7:0] extPins;
		logic extIrqPin0;
		logic extIrqPin1;
	} ifp_pins_t;
	typedef struct packed {
		logic [2:0] pwmEvent;
		logic timer0Overflow;
		logic timer1Overflow;
	} ifp_events_t;
endpackage

/* File: design/ifp_ctrl.sv */
// Interrupt enable, flag and power-mode control block with an Avalon-MM slave.
`timescale 1ns/1ps
module ifp_ctrl (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Avalon-MM slave.
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Pins (asynchronous) and same-clock events.
	input wire ifp_pkg::ifp_pins_t pins,
	input wire ifp_pkg::ifp_events_t events,
	input wire ifp_pkg::ifp_ack_t vectorAck,
	// Status toward the core.
	output logic [7:0] pinIrqReq,
	output logic [2:0] pwmIrqReq,
	output logic extIrq0Req,
	output logic extIrq1Req,
	output logic timer0IrqReq,
	output logic timer1IrqReq,
	output logic wakeUp,
	output logic stopMode,
	output logic idleMode,
	output logic uart1DoubleBaud,
	output logic timer0Run,
	output logic timer1Run,
	output logic irq
);
	logic [7:0] pinEn_reg, pinFlags_reg, pwmFlags_reg, power_reg, tctrl_reg;
	logic lowVoltGate_reg;
	logic [2:0] status_reg, mask_reg;
	logic [9:0] syncA_reg, syncB_reg, syncPrev_reg;
	logic ackPhase_reg;
	logic [31:0] readdata_next;
	logic wrEn, rdEn;
	logic [7:0] wByte, pinActive, pinRise;
	logic fall0, fall1, pinWake, anyWake;

	// Bus accesses complete in two cycles: waitrequest drops on the second one.
	assign wrEn = write && ackPhase_reg;
	assign rdEn = read && ackPhase_reg;
	assign wByte = byteenable[0] ? writedata[7:0] : 8'h00;

	// Two-flop synchroniser for every pin; only the second stage and its one-edge delayed copy feed logic.
	always_ff @(posedge clk) begin
		if (rst) begin
			syncA_reg <= 10'h3ff;
			syncB_reg <= 10'h3ff;
			syncPrev_reg <= 10'h3ff;
		end else begin
			syncA_reg <= {pins.extIrqPin1, pins.extIrqPin0, pins.extPins};
			syncB_reg <= syncA_reg;
			syncPrev_reg <= syncB_reg;
		end
	end

	// Extra pins assert on a rising edge of the synchronised level.
	assign pinRise = syncB_reg[7:0] & ~syncPrev_reg[7:0];
	assign pinActive = pinRise & pinEn_reg & {8{lowVoltGate_reg}};
	assign fall0 = syncPrev_reg[8] & ~syncB_reg[8];
	assign fall1 = syncPrev_reg[9] & ~syncB_reg[9];
	// Global enable is not consulted here, so wake-up works with it clear.
	assign pinWake = |(pinFlags_reg & pinEn_reg) && lowVoltGate_reg;
	assign anyWake = pinWake || (|pwmFlags_reg) || extIrq0Req || extIrq1Req || timer0IrqReq || timer1IrqReq;

	// Waitrequest handshake: one wait cycle per access.
	always_ff @(posedge clk) begin
		if (rst) begin
			ackPhase_reg <= 1'b0;
		end else begin
			ackPhase_reg <= (read || write) && !ackPhase_reg;
		end
	end

	// Enable register and low-voltage gate are plain read/write.
	always_ff @(posedge clk) begin
		if (rst) begin
			pinEn_reg <= ifp_pkg::RESET_BYTE;
			lowVoltGate_reg <= 1'b0;
		end else if (wrEn && byteenable[0]) begin
			if (address == ifp_pkg::OFS_PIN_EN) begin
				pinEn_reg <= wByte;
			end
			if (address == ifp_pkg::OFS_CTRL) begin
				lowVoltGate_reg <= wByte[0];
			end
		end
	end

	// A write to the enable register lands whole on the next edge.
	property p_enWrite;
		@(posedge clk) disable iff (rst) (wrEn && byteenable[0] && address == ifp_pkg::OFS_PIN_EN)
			|=> pinEn_reg == $past(wByte);
	endproperty
	a_enWrite: assert property (p_enWrite) else $error("Enable register write lost.");

	// Pin flags: zero clears, one leaves alone, and a new event wins over a clear.
	always_ff @(posedge clk) begin
		if (rst) begin
			pinFlags_reg <= ifp_pkg::RESET_BYTE;
		end else if (wrEn && byteenable[0] && address == ifp_pkg::OFS_PIN_FLAGS) begin
			pinFlags_reg <= (pinFlags_reg & wByte) | pinActive;
		end else begin
			pinFlags_reg <= pinFlags_reg | pinActive;
		end
	end

	// A zero written to a pin flag clears it unless an event lands at once.
	property p_pinClear;
		@(posedge clk) disable iff (rst) (wrEn && byteenable[0] && address == ifp_pkg::OFS_PIN_FLAGS)
			|=> (pinFlags_reg & ~$past(wByte) & ~$past(pinActive)) == 8'h00;
	endproperty
	a_pinClear: assert property (p_pinClear) else $error("Pin flag survived a zero write.");

	// PWM flags behave the same way on the low three bits.
	always_ff @(posedge clk) begin
		if (rst) begin
			pwmFlags_reg <= ifp_pkg::RESET_BYTE;
		end else if (wrEn && byteenable[0] && address == ifp_pkg::OFS_PWM_FLAGS) begin
			pwmFlags_reg <= ((pwmFlags_reg & wByte) | {5'h00, events.pwmEvent}) & ifp_pkg::PWM_FLAG_MASK;
		end else begin
			pwmFlags_reg <= pwmFlags_reg | {5'h00, events.pwmEvent};
		end
	end

	// Every PWM event leaves its flag standing on the next edge.
	property p_pwmSet;
		@(posedge clk) disable iff (rst) (|events.pwmEvent)
			|=> (pwmFlags_reg[2:0] & $past(events.pwmEvent)) == $past(events.pwmEvent);
	endproperty
	a_pwmSet: assert property (p_pwmSet) else $error("PWM flag not set by event.");
	// Only hardware may raise a PWM flag; a written one is ignored.
	property p_pwmNoWriteSet;
		@(posedge clk) disable iff (rst) (wrEn && address == ifp_pkg::OFS_PWM_FLAGS && events.pwmEvent == 3'h0)
			|=> (pwmFlags_reg & ~$past(pwmFlags_reg)) == 8'h00;
	endproperty
	a_pwmNoWriteSet: assert property (p_pwmNoWriteSet) else $error("Writing one set a PWM flag.");

	// Power control; a pending wake source drops both sleep requests.
	always_ff @(posedge clk) begin
		if (rst) begin
			power_reg <= ifp_pkg::RESET_BYTE;
		end else if (wrEn && byteenable[0] && address == ifp_pkg::OFS_POWER) begin
			power_reg <= wByte & ifp_pkg::POWER_RW_MASK;
		end else if (anyWake) begin
			power_reg[ifp_pkg::BIT_POWER_DOWN] <= 1'b0;
			power_reg[ifp_pkg::BIT_IDLE] <= 1'b0;
		end
	end

	// A power write stores the writable bits; the rest read as zero.
	property p_powerWrite;
		@(posedge clk) disable iff (rst) (wrEn && byteenable[0] && address == ifp_pkg::OFS_POWER)
			|=> power_reg == ($past(wByte) & ifp_pkg::POWER_RW_MASK);
	endproperty
	a_powerWrite: assert property (p_powerWrite) else $error("Power write not stored.");
	// The sleep outputs follow their bits one edge later.
	property p_sleepOut;
		@(posedge clk) disable iff (rst) ##1 {stopMode, idleMode} == $past(power_reg[1:0]);
	endproperty
	a_sleepOut: assert property (p_sleepOut) else $error("Sleep outputs do not follow power bits.");

	// Timer and external-interrupt control; hardware set wins over vector clear.
	always_ff @(posedge clk) begin
		if (rst) begin
			tctrl_reg <= ifp_pkg::RESET_BYTE;
		end else begin
			if (wrEn && byteenable[0] && address == ifp_pkg::OFS_TCTRL) begin
				tctrl_reg <= wByte;
			end else begin
				if (vectorAck == ifp_pkg::ACK_TIMER1) begin
					tctrl_reg[ifp_pkg::BIT_T1_OVF] <= 1'b0;
				end
				if (vectorAck == ifp_pkg::ACK_TIMER0) begin
					tctrl_reg[ifp_pkg::BIT_T0_OVF] <= 1'b0;
				end
				if (vectorAck == ifp_pkg::ACK_PIN1) begin
					tctrl_reg[ifp_pkg::BIT_P1_EDGE] <= 1'b0;
				end
				if (vectorAck == ifp_pkg::ACK_PIN0) begin
					tctrl_reg[ifp_pkg::BIT_P0_EDGE] <= 1'b0;
				end
			end
			if (events.timer1Overflow) begin
				tctrl_reg[ifp_pkg::BIT_T1_OVF] <= 1'b1;
			end
			if (events.timer0Overflow) begin
				tctrl_reg[ifp_pkg::BIT_T0_OVF] <= 1'b1;
			end
			if (fall1 && tctrl_reg[ifp_pkg::BIT_P1_TRIG]) begin
				tctrl_reg[ifp_pkg::BIT_P1_EDGE] <= 1'b1;
			end
			if (fall0 && tctrl_reg[ifp_pkg::BIT_P0_TRIG]) begin
				tctrl_reg[ifp_pkg::BIT_P0_EDGE] <= 1'b1;
			end
		end
	end

	// Edge flags rise on a detected fall only when edge mode is chosen.
	property p_p1EdgeSet;
		@(posedge clk) disable iff (rst) (fall1 && tctrl_reg[ifp_pkg::BIT_P1_TRIG]) |=> tctrl_reg[ifp_pkg::BIT_P1_EDGE];
	endproperty
	a_p1EdgeSet: assert property (p_p1EdgeSet) else $error("Pin1 fall not flagged.");
	property p_p0EdgeSet;
		@(posedge clk) disable iff (rst) (fall0 && tctrl_reg[ifp_pkg::BIT_P0_TRIG]) |=> tctrl_reg[ifp_pkg::BIT_P0_EDGE];
	endproperty
	a_p0EdgeSet: assert property (p_p0EdgeSet) else $error("Pin0 fall not flagged.");
	// A vector clears its own flag when no new event or write competes.
	property p_p1Clear;
		@(posedge clk) disable iff (rst) (vectorAck == ifp_pkg::ACK_PIN1 && !fall1 && !wrEn)
			|=> !tctrl_reg[ifp_pkg::BIT_P1_EDGE];
	endproperty
	a_p1Clear: assert property (p_p1Clear) else $error("Pin1 flag not cleared on vector.");
	property p_p0Clear;
		@(posedge clk) disable iff (rst) (vectorAck == ifp_pkg::ACK_PIN0 && !fall0 && !wrEn)
			|=> !tctrl_reg[ifp_pkg::BIT_P0_EDGE];
	endproperty
	a_p0Clear: assert property (p_p0Clear) else $error("Pin0 flag not cleared on vector.");
	property p_t1Clear;
		@(posedge clk) disable iff (rst) (vectorAck == ifp_pkg::ACK_TIMER1 && !events.timer1Overflow && !wrEn)
			|=> !tctrl_reg[ifp_pkg::BIT_T1_OVF];
	endproperty
	a_t1Clear: assert property (p_t1Clear) else $error("Timer1 flag not cleared on vector.");
	// Level mode passes the synchronised low level through with no latch.
	property p_level1;
		@(posedge clk) disable iff (rst) !tctrl_reg[ifp_pkg::BIT_P1_TRIG] |=> extIrq1Req == !$past(syncB_reg[9]);
	endproperty
	a_level1: assert property (p_level1) else $error("Pin1 level request wrong.");
	// The run outputs copy their control bits one edge later.
	property p_runOut;
		@(posedge clk) disable iff (rst)
			##1 {timer1Run, timer0Run} == $past({tctrl_reg[ifp_pkg::BIT_T1_RUN], tctrl_reg[ifp_pkg::BIT_T0_RUN]});
	endproperty
	a_runOut: assert property (p_runOut) else $error("Timer run outputs wrong.");

	// Interrupt status: pin, PWM and classic pin-fall events (no timer overflows); write one clears, set wins.
	always_ff @(posedge clk) begin
		if (rst) begin
			status_reg <= 3'h0;
			mask_reg <= 3'h0;
		end else begin
			if (wrEn && byteenable[0] && address == ifp_pkg::OFS_IRQ_MASK) begin
				mask_reg <= wByte[2:0];
			end
			if (wrEn && byteenable[0] && address == ifp_pkg::OFS_IRQ_STATUS) begin
				status_reg <= (status_reg & ~wByte[2:0]) | {fall0 | fall1, |events.pwmEvent, |pinActive};
			end else begin
				status_reg <= status_reg | {fall0 | fall1, |events.pwmEvent, |pinActive};
			end
		end
	end

	// Read mux; unmapped addresses return zero.
	always_comb begin
		readdata_next = ifp_pkg::READ_UNMAPPED;
		case (address)
			ifp_pkg::OFS_PIN_EN: readdata_next = {24'h000000, pinEn_reg};
			ifp_pkg::OFS_PIN_FLAGS: readdata_next = {24'h000000, pinFlags_reg};
			ifp_pkg::OFS_PWM_FLAGS: readdata_next = {24'h000000, pwmFlags_reg};
			ifp_pkg::OFS_POWER: readdata_next = {24'h000000, power_reg};
			ifp_pkg::OFS_TCTRL: readdata_next = {24'h000000, tctrl_reg};
			ifp_pkg::OFS_CTRL: readdata_next = {31'h00000000, lowVoltGate_reg};
			ifp_pkg::OFS_IRQ_STATUS: readdata_next = {29'h00000000, status_reg};
			ifp_pkg::OFS_IRQ_MASK: readdata_next = {29'h00000000, mask_reg};
			default: readdata_next = ifp_pkg::READ_UNMAPPED;
		endcase
	end

	// Bus outputs registered; readdata is loaded on the wait cycle so it stands at release.
	always_ff @(posedge clk) begin
		if (rst) begin
			readdata <= 32'h00000000;
			waitrequest <= 1'b1;
		end else begin
			readdata <= (read && !ackPhase_reg) ? readdata_next : readdata;
			waitrequest <= !((read || write) && !ackPhase_reg);
		end
	end

	// Registered requests; level mode tracks the pin low with no latching.
	always_ff @(posedge clk) begin
		if (rst) begin
			pinIrqReq <= 8'h00;
			pwmIrqReq <= 3'h0;
			extIrq0Req <= 1'b0;
			extIrq1Req <= 1'b0;
			timer0IrqReq <= 1'b0;
			timer1IrqReq <= 1'b0;
			wakeUp <= 1'b0;
			stopMode <= 1'b0;
			idleMode <= 1'b0;
			uart1DoubleBaud <= 1'b0;
			timer0Run <= 1'b0;
			timer1Run <= 1'b0;
			irq <= 1'b0;
		end else begin
			pinIrqReq <= pinFlags_reg & pinEn_reg & {8{lowVoltGate_reg}};
			pwmIrqReq <= pwmFlags_reg[2:0];
			extIrq0Req <= tctrl_reg[ifp_pkg::BIT_P0_TRIG] ? tctrl_reg[ifp_pkg::BIT_P0_EDGE] : !syncB_reg[8];
			extIrq1Req <= tctrl_reg[ifp_pkg::BIT_P1_TRIG] ? tctrl_reg[ifp_pkg::BIT_P1_EDGE] : !syncB_reg[9];
			timer0IrqReq <= tctrl_reg[ifp_pkg::BIT_T0_OVF];
			timer1IrqReq <= tctrl_reg[ifp_pkg::BIT_T1_OVF];
			wakeUp <= pinWake;
			stopMode <= power_reg[ifp_pkg::BIT_POWER_DOWN];
			idleMode <= power_reg[ifp_pkg::BIT_IDLE];
			uart1DoubleBaud <= power_reg[ifp_pkg::BIT_DOUBLE_BAUD];
			timer0Run <= tctrl_reg[ifp_pkg::BIT_T0_RUN];
			timer1Run <= tctrl_reg[ifp_pkg::BIT_T1_RUN];
			irq <= |(status_reg & mask_reg);
		end
	end

	// Checks on the block's own behaviour.
	property p_pinFlagSet;
		@(posedge clk) disable iff (rst) (|pinActive) |=> ((pinFlags_reg & $past(pinActive)) == $past(pinActive));
	endproperty
	a_pinFlagSet: assert property (p_pinFlagSet) else $error("Pin flag not set by event.");
	property p_noWriteSet;
		@(posedge clk) disable iff (rst) (wrEn && address == ifp_pkg::OFS_PIN_FLAGS && pinActive == 8'h00)
			|=> (pinFlags_reg & ~$past(pinFlags_reg)) == 8'h00;
	endproperty
	a_noWriteSet: assert property (p_noWriteSet) else $error("Writing one set a pin flag.");
	property p_gateOff;
		@(posedge clk) disable iff (rst) !lowVoltGate_reg |-> pinActive == 8'h00 && !pinWake;
	endproperty
	a_gateOff: assert property (p_gateOff) else $error("Pin request without low-volt gate.");
	// Overflow flagging is two steps: the flag, then the request one edge later.
	sequence s_t1Flagged;
		tctrl_reg[ifp_pkg::BIT_T1_OVF] ##1 timer1IrqReq;
	endsequence
	property p_t1Set;
		@(posedge clk) disable iff (rst) events.timer1Overflow |=> s_t1Flagged;
	endproperty
	a_t1Set: assert property (p_t1Set) else $error("Timer1 overflow not flagged.");
	sequence s_t0Flagged;
		tctrl_reg[ifp_pkg::BIT_T0_OVF] ##1 timer0IrqReq;
	endsequence
	property p_t0Set;
		@(posedge clk) disable iff (rst) events.timer0Overflow |=> s_t0Flagged;
	endproperty
	a_t0Set: assert property (p_t0Set) else $error("Timer0 overflow not flagged.");
	property p_t0Clear;
		@(posedge clk) disable iff (rst) (vectorAck == ifp_pkg::ACK_TIMER0 && !events.timer0Overflow && !wrEn)
			|=> !tctrl_reg[ifp_pkg::BIT_T0_OVF];
	endproperty
	a_t0Clear: assert property (p_t0Clear) else $error("Timer0 flag not cleared on vector.");
	property p_levelFollow;
		@(posedge clk) disable iff (rst) (!tctrl_reg[ifp_pkg::BIT_P0_TRIG] && syncB_reg[8]) |=> !extIrq0Req;
	endproperty
	a_levelFollow: assert property (p_levelFollow) else $error("Level request held after pin high.");
	// Waking is two steps: the sleep bits drop, then the mode outputs follow.
	sequence s_sleepDropped;
		power_reg[1:0] == 2'b00 ##1 (!stopMode && !idleMode);
	endsequence
	property p_wakeClears;
		@(posedge clk) disable iff (rst) (anyWake && !wrEn) |=> s_sleepDropped;
	endproperty
	a_wakeClears: assert property (p_wakeClears) else $error("Sleep bits not cleared on wake.");
	property p_baud;
		@(posedge clk) disable iff (rst) ##1 uart1DoubleBaud == $past(power_reg[ifp_pkg::BIT_DOUBLE_BAUD]);
	endproperty
	a_baud: assert property (p_baud) else $error("Double baud output mismatch.");
	// Pin requests need both the pin's enable and the low-volt gate.
	property p_pinReqGate;
		@(posedge clk) disable iff (rst) !lowVoltGate_reg |=> pinIrqReq == 8'h00;
	endproperty
	a_pinReqGate: assert property (p_pinReqGate) else $error("Pin request with gate closed.");
	property p_pinReqEn;
		@(posedge clk) disable iff (rst) ##1 (pinIrqReq & ~$past(pinEn_reg)) == 8'h00;
	endproperty
	a_pinReqEn: assert property (p_pinReqEn) else $error("Request from a disabled pin.");
	// Wake follows an enabled flag whatever the core's global enable holds.
	property p_wakeOut;
		@(posedge clk) disable iff (rst) pinWake |=> wakeUp;
	endproperty
	a_wakeOut: assert property (p_wakeOut) else $error("Enabled pin flag did not wake.");
endmodule

/* File: dv/ifp_partner.sv */
// Behavioural model of the core and pin side that feeds the block.
`timescale 1ns/1ps
module ifp_partner (
	// Clock.
	input wire logic clk,
	// Pin levels, events and vector acknowledges.
	output ifp_pkg::ifp_pins_t pins,
	output ifp_pkg::ifp_events_t events,
	output ifp_pkg::ifp_ack_t vectorAck
);
	// Classic pins start at their high idle level and extra pins low, so no false edge follows reset.
	initial begin
		pins = {8'h00, 2'b11};
		events = '0;
		vectorAck = ifp_pkg::ACK_NONE;
	end
	// Pin changes land just after an edge, as an unrelated source might.
	task automatic setPins(input ifp_pkg::ifp_pins_t p);
		@(posedge clk);
		pins <= p;
	endtask
	// Hardware events are one-cycle pulses.
	task automatic pulseEvents(input ifp_pkg::ifp_events_t e);
		@(posedge clk);
		events <= e;
		@(posedge clk);
		events <= '0;
	endtask
	// A vector acknowledge is a one-cycle pulse.
	task automatic ackVector(input ifp_pkg::ifp_ack_t a);
		@(posedge clk);
		vectorAck <= a;
		@(posedge clk);
		vectorAck <= ifp_pkg::ACK_NONE;
	endtask
endmodule

/* File: dv/ifp_ctrl_tb.sv */
// Self-checking testbench for the interrupt flag and power control block.
`timescale 1ns/1ps
module ifp_ctrl_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] address = 8'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h00000000;
	logic [3:0] byteenable = 4'h0;
	logic [31:0] readdata;
	logic waitrequest;
	ifp_pkg::ifp_pins_t pins;
	ifp_pkg::ifp_events_t events;
	ifp_pkg::ifp_ack_t vectorAck;
	logic [7:0] pinIrqReq;
	logic [2:0] pwmIrqReq;
	logic extIrq0Req, extIrq1Req, timer0IrqReq, timer1IrqReq, wakeUp, stopMode, idleMode;
	logic uart1DoubleBaud, timer0Run, timer1Run, irq;
	int bad_count = 0;
	int n_checks = 0;
	// A 125 MHz clock.
	always #4 clk = ~clk;
	// The block and its far side.
	ifp_ctrl dut_u (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
		.pins(pins), .events(events), .vectorAck(vectorAck), .pinIrqReq(pinIrqReq), .pwmIrqReq(pwmIrqReq),
		.extIrq0Req(extIrq0Req), .extIrq1Req(extIrq1Req), .timer0IrqReq(timer0IrqReq),
		.timer1IrqReq(timer1IrqReq), .wakeUp(wakeUp), .stopMode(stopMode), .idleMode(idleMode),
		.uart1DoubleBaud(uart1DoubleBaud), .timer0Run(timer0Run), .timer1Run(timer1Run), .irq(irq));
	ifp_partner partner_u (.clk(clk), .pins(pins), .events(events), .vectorAck(vectorAck));
	// Verdict and end of run.
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Compare with case inequality so an unknown never matches.
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One bus access; the request stands until waitrequest is sampled low.
	task automatic busAccess(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
		int n;
		@(posedge clk);
		address <= a;
		writedata <= {24'h000000, d};
		byteenable <= 4'hf;
		write <= wr;
		read <= !wr;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		q = readdata;
		write <= 1'b0;
		read <= 1'b0;
		if (n >= 50) begin
			bad_count++;
			end_sim();
		end
	endtask
	// A write, then two edges so registered outputs settle.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		busAccess(1'b1, a, d, q);
		cycles(2);
	endtask
	task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		busAccess(1'b0, a, 8'h00, q);
		check(what, q, exp);
	endtask
	// Registers clear at reset; an unmapped place reads zero and drops writes.
	task automatic testReset();
		rdChk("enable", 8'h84, 0);
		rdChk("pinFlags", 8'h85, 0);
		rdChk("pwmFlags", 8'h86, 0);
		rdChk("power", 8'h87, 0);
		rdChk("tctrl", 8'h88, 0);
		wr(8'h80, 8'h5a);
		rdChk("unmapped", 8'h80, 0);
	endtask
	// Nothing is pending, so the sleep bits stay as written.
	task automatic testPower();
		wr(8'h87, 8'hff);
		rdChk("power", 8'h87, 8'h8f);
		check("modes", {uart1DoubleBaud, stopMode, idleMode}, 3'b111);
		wr(8'h87, 8'h0c);
		rdChk("spare", 8'h87, 8'h0c);
		check("modesOff", {uart1DoubleBaud, stopMode, idleMode}, 0);
	endtask
	task automatic testTimers();
		wr(8'h88, 8'h50);
		check("runs", {timer1Run, timer0Run}, 2'b11);
		partner_u.pulseEvents(5'b00001);
		cycles(3);
		check("t1Req", timer1IrqReq, 1);
		rdChk("t1Flag", 8'h88, 8'hd0);
		partner_u.ackVector(ifp_pkg::ACK_TIMER1);
		rdChk("t1Clear", 8'h88, 8'h50);
		partner_u.pulseEvents(5'b00010);
		rdChk("t0Flag", 8'h88, 8'h70);
		check("t0Req", timer0IrqReq, 1);
		partner_u.ackVector(ifp_pkg::ACK_TIMER0);
		rdChk("t0Clear", 8'h88, 8'h50);
		wr(8'h88, 8'h00);
		check("stopped", {timer1Run, timer0Run}, 0);
	endtask
	// Edge mode latches a fall until the vector; level mode follows the pin.
	task automatic testExtPins();
		wr(8'h88, 8'h05);
		partner_u.setPins({8'h00, 2'b01});
		cycles(5);
		check("p0Req", extIrq0Req, 1);
		rdChk("p0Flag", 8'h88, 8'h07);
		partner_u.ackVector(ifp_pkg::ACK_PIN0);
		rdChk("p0Clear", 8'h88, 8'h05);
		partner_u.setPins({8'h00, 2'b00});
		cycles(5);
		rdChk("p1Flag", 8'h88, 8'h0d);
		partner_u.ackVector(ifp_pkg::ACK_PIN1);
		rdChk("p1Clear", 8'h88, 8'h05);
		wr(8'h88, 8'h00);
		check("lvlReq", {extIrq0Req, extIrq1Req}, 2'b11);
		partner_u.setPins({8'h00, 2'b11});
		cycles(5);
		check("lvlOff", {extIrq0Req, extIrq1Req}, 2'b00);
	endtask
	// The top pin wakes the sleeping device only once the gate is open.
	task automatic testPinWake();
		wr(8'h84, 8'h80);
		rdChk("enable", 8'h84, 8'h80);
		wr(8'h87, 8'h03);
		partner_u.setPins({8'h80, 2'b11});
		cycles(6);
		check("gated", {wakeUp, stopMode, pinIrqReq}, 10'h100);
		partner_u.setPins({8'h00, 2'b11});
		wr(8'h85, 8'h00);
		wr(8'h8c, 8'h01);
		partner_u.setPins({8'h80, 2'b11});
		cycles(6);
		check("wake", wakeUp, 1);
		check("pin9Req", pinIrqReq, 8'h80);
		rdChk("sleepClear", 8'h87, 8'h00);
		rdChk("pinFlag", 8'h85, 8'h80);
		wr(8'h85, 8'hff);
		rdChk("pinOne", 8'h85, 8'h80);
		wr(8'h85, 8'h00);
		rdChk("pinZero", 8'h85, 8'h00);
	endtask
	// PWM flags, then the status, mask and level interrupt.
	task automatic testPwmIrq();
		partner_u.pulseEvents(5'b10100);
		rdChk("pwmSet", 8'h86, 8'h05);
		check("pwmReq", pwmIrqReq, 3'b101);
		wr(8'h86, 8'hff);
		rdChk("pwmOne", 8'h86, 8'h05);
		wr(8'h86, 8'h04);
		rdChk("pwmZero", 8'h86, 8'h04);
		rdChk("status", 8'h90, 8'h07);
		wr(8'h94, 8'h00);
		check("masked", irq, 0);
		wr(8'h94, 8'h02);
		check("irqOn", irq, 1);
		wr(8'h90, 8'h07);
		check("irqOff", irq, 0);
		rdChk("statusClr", 8'h90, 0);
	endtask
	// A second reset in mid-run returns written state to zero.
	task automatic testMidReset();
		wr(8'h87, 8'h8c);
		check("baudOn", uart1DoubleBaud, 1);
		@(posedge clk);
		rst <= 1'b1;
		cycles(4);
		rst <= 1'b0;
		check("baudOff", uart1DoubleBaud, 0);
		rdChk("enReset", 8'h84, 0);
		rdChk("powerReset", 8'h87, 0);
		rdChk("pwmReset", 8'h86, 0);
	endtask
	// Reset for four cycles, then the scenarios in turn.
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		testReset();
		testPower();
		testTimers();
		testExtPins();
		testPinWake();
		testPwmIrq();
		testMidReset();
		end_sim();
	end
endmodule
